// *** rtl/core_store_pkg.sv ***
// Constants, types and state layout for the core store timing block.
package core_store_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          DATA_W   = 24;      // Word width, one plane per bit
  localparam int          GROUPS   = 3;       // Transfer stages in the fan-out
  localparam int          STAGE_W  = 8;       // Outputs per transfer stage
  localparam int          TIME_W   = 5;       // Memory time counter width

  // ----------------------------------------------------------------
  // Memory times, one clock cycle each
  // ----------------------------------------------------------------
  localparam logic [4:0]  T_READ_ON   = 5'h03; // Start read stretcher
  localparam logic [4:0]  T_PROBE     = 5'h05; // Read probes set
  localparam logic [4:0]  T_INH_SET   = 5'h08; // Flags set, output stage loaded
  localparam logic [4:0]  T_INH_TEST  = 5'h09; // Output stage clears flags
  localparam logic [4:0]  T_READ_OFF  = 5'h09; // Stop read discharger
  localparam logic [4:0]  T_INH_START = 5'h0a; // Flags sampled into generators
  localparam logic [4:0]  T_WRITE_ON  = 5'h0b; // Start write stretcher
  localparam logic [4:0]  T_WRITE_OFF = 5'h11; // Stop write discharger
  localparam logic [4:0]  T_XLATE_OFF = 5'h12; // Stop translation issued
  localparam logic [4:0]  T_DIST_FAN  = 5'h13; // Disturb event into stages
  localparam logic [4:0]  T_DIST_ON   = 5'h14; // Disturb reaches the planes
  localparam logic [4:0]  T_END       = 5'h17; // Stop inhibit/disturb, done

  // ----------------------------------------------------------------
  // Word constants, all zeros and all ones
  // ----------------------------------------------------------------
  localparam logic [23:0] WORD_ZERO = 24'h000000;
  localparam logic [23:0] WORD_ONES = 24'hffffff;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } seq_e;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_e        st;          // Sequencer state
    logic [4:0]  t;           // Memory time within the reference
    logic        read_on;     // Read pulse stretcher
    logic        write_on;    // Write pulse stretcher
    logic        xlate_on;    // Address translation live
    logic        stop_xlate;  // Stop translation event
    logic [3:0]  probe_req;   // Probe groups asked for
    logic [3:0]  probe;       // Read probe cores
    logic [2:0]  dist_stage;  // Disturb transfer stages
    logic [23:0] start_dist;  // Per-plane disturb start
    logic [23:0] stop_dist;   // Per-plane inhibit/disturb stop
    logic [23:0] inh_flag;    // Inhibit control flags
    logic [23:0] z_out;       // Data register output stage
    logic [23:0] inh_gen;     // Inhibit/disturb generators
    logic [23:0] mdr;         // Memory data register
    logic [23:0] sense_s1;    // Sense synchroniser, first
    logic [23:0] sense_s2;    // Sense synchroniser, second
  } core_state_s;

endpackage : core_store_pkg

// *** rtl/core_store_timing.sv ***
// Memory timing chain and 24 digit plane controls for the core store.
`timescale 1ns/1ns
module core_store_timing (
  input  wire logic        clk,           // 25 MHz system clock
  input  wire logic        rst,           // Asynchronous, active high
  input  wire logic        start_ref,     // Storage request pulse
  input  wire logic        read_ref,      // Request is a read
  input  wire logic [3:0]  probe_req,     // Kept groups for partial write
  input  wire logic        load_data,     // Load word into data register
  input  wire logic        clear_data,    // Clear data register
  input  wire logic [23:0] write_word,    // Word to be written
  input  wire logic [23:0] sense_in,      // Sense amplifier outputs
  output logic             busy,          // Reference in progress
  output logic [4:0]       mem_time,      // Current memory time
  output logic             read_cur,      // Read current on
  output logic             write_cur,     // Write current on
  output logic             xlate_on,      // Address translation on
  output logic             stop_xlate,    // Stop translation pulse
  output logic [3:0]       read_probe,    // Read probe groups
  output logic [23:0]      start_disturb, // Per-plane disturb start
  output logic [23:0]      stop_inhib,    // Per-plane generator stop
  output logic [23:0]      inhibit_gen,   // Per-plane inhibit/disturb on
  output logic [23:0]      data_reg       // Memory data register
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expand probe groups 0-7, 8-14, 15, 16-23 to bit lanes
  function automatic logic [23:0] probe_mask(input logic [3:0] g);
    probe_mask = {{8{g[3]}}, g[2], {7{g[1]}}, {8{g[0]}}};
  endfunction : probe_mask

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  core_store_pkg::core_state_s s;       // Registered state
  core_store_pkg::core_state_s next_s;  // Next state
  logic                        run;     // Sequencer running

  assign run = (s.st == core_store_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Whole sequence in one process; every reference is the same chain
  always_comb begin
    next_s = s;
    // Sense lines come from analog pins: two flops before use
    next_s.sense_s1   = sense_in;
    next_s.sense_s2   = s.sense_s1;
    // Single-cycle events drop by default
    next_s.stop_xlate = 1'b0;
    next_s.dist_stage = 3'h0;
    next_s.start_dist = core_store_pkg::WORD_ZERO;
    next_s.stop_dist  = core_store_pkg::WORD_ZERO;
    case (s.st)
      core_store_pkg::ST_IDLE: begin
        // Computer prepares the word only between references
        if (clear_data) begin
          next_s.mdr = core_store_pkg::WORD_ZERO;
        end else if (load_data) begin
          next_s.mdr = write_word;
        end
        if (start_ref) begin
          next_s.st        = core_store_pkg::ST_RUN;
          next_s.t         = 5'h00;
          next_s.xlate_on  = 1'b1;
          // Read takes the whole word, write only the kept groups
          next_s.probe_req = read_ref ? 4'hf : probe_req;
        end
      end
      core_store_pkg::ST_RUN: begin
        next_s.t = 5'(s.t + 5'h01);
        // Probe cores set; replaced groups stay unprobed
        if (s.t == core_store_pkg::T_PROBE) begin
          next_s.probe = s.probe_req;
        end
        // Read current window
        if (s.t == core_store_pkg::T_READ_ON) begin
          next_s.read_on = 1'b1;
        end
        if (s.t == core_store_pkg::T_READ_OFF) begin
          next_s.read_on = 1'b0;
        end
        // Capture sensed ones only where probed; zeros leave bits alone
        if (s.read_on) begin
          next_s.mdr = s.mdr | (s.sense_s2 & probe_mask(s.probe));
        end
        // Digit plane controls, all 24 bits in parallel
        if (s.t == core_store_pkg::T_INH_SET) begin
          next_s.inh_flag = core_store_pkg::WORD_ONES;
          next_s.z_out    = s.mdr;
        end
        if (s.t == core_store_pkg::T_INH_TEST) begin
          next_s.inh_flag = s.inh_flag & ~s.z_out;
        end
        // Restore after read uses this same path from the register
        if (s.t == core_store_pkg::T_INH_START) begin
          next_s.inh_gen = s.inh_gen | s.inh_flag;
        end
        // Write current window, shared by write and restore
        if (s.t == core_store_pkg::T_WRITE_ON) begin
          next_s.write_on = 1'b1;
        end
        if (s.t == core_store_pkg::T_WRITE_OFF) begin
          next_s.write_on = 1'b0;
        end
        // Translation ends right after write, before disturb
        if (s.t == core_store_pkg::T_XLATE_OFF) begin
          next_s.stop_xlate = 1'b1;
          next_s.xlate_on   = 1'b0;
        end
        // Disturb event passes three transfer stages of eight
        if (s.t == core_store_pkg::T_DIST_FAN) begin
          next_s.dist_stage = 3'h7;
        end
        for (int g = 0; g < core_store_pkg::GROUPS; g++) begin
          next_s.start_dist[g*core_store_pkg::STAGE_W +: core_store_pkg::STAGE_W] =
            {core_store_pkg::STAGE_W{s.dist_stage[g]}};
        end
        // Generators latch on and hold until their stop
        next_s.inh_gen = next_s.inh_gen | s.start_dist;
        // End of reference: stop every generator, back to idle
        if (s.t == core_store_pkg::T_END) begin
          next_s.stop_dist = core_store_pkg::WORD_ONES;
          next_s.inh_gen   = core_store_pkg::WORD_ZERO;
          next_s.probe     = 4'h0;
          next_s.st        = core_store_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.st = core_store_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Constants only under reset; nothing is sampled here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------------------------------
  assign busy          = run;
  assign mem_time      = s.t;
  assign read_cur      = s.read_on;
  assign write_cur     = s.write_on;
  assign xlate_on      = s.xlate_on;
  assign stop_xlate    = s.stop_xlate;
  assign read_probe    = s.probe;
  assign start_disturb = s.start_dist;
  assign stop_inhib    = s.stop_dist;
  assign inhibit_gen   = s.inh_gen;
  assign data_reg      = s.mdr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Read window is exactly times 4 through 9
  chk_read_window: assert property ($rose(s.read_on) |-> $past(s.t) == 5'h03
    && run ##1 s.read_on [*5] ##1 !s.read_on)
    else $error("read current window wrong");

  // Read always starts the cycle after time 3
  chk_read_start: assert property (run && s.t == 5'h03 |=> s.read_on)
    else $error("read current did not start");

  // Write window is exactly times 12 through 17
  chk_write_window: assert property ($rose(s.write_on) |-> $past(s.t) == 5'h0b
    ##1 s.write_on [*5] ##1 !s.write_on)
    else $error("write current window wrong");

  // Translation stops with its pulse, after write ends
  chk_xlate_stop: assert property (s.stop_xlate |-> !s.xlate_on && s.t == 5'h13
    && !s.write_on && s.start_dist == 24'h000000)
    else $error("translation stop misplaced");

  // Data one at time 8 clears its flag, zero keeps it
  chk_inhib_select: assert property (run && s.t == 5'h08 |=>
    ##1 s.inh_flag == ~$past(s.mdr, 2))
    else $error("inhibit flag does not follow data");

  // Generators follow the inverted data word held at time 8
  chk_inhib_start: assert property (run && s.t == 5'h0a |=>
    s.inh_gen == ~$past(s.mdr, 3))
    else $error("inhibit generator start wrong");

  // Generators hold until the stop, on every plane
  chk_gen_hold: assert property (run && s.t > 5'h0b && s.t < 5'h17 |=>
    (s.inh_gen & $past(s.inh_gen)) == $past(s.inh_gen))
    else $error("generator dropped early");

  // Stop reaches all planes and clears generators
  chk_stop_all: assert property (run && s.t == 5'h17 |=>
    s.stop_dist == 24'hffffff && s.inh_gen == 24'h000000 && !run)
    else $error("end of reference stop wrong");

  // Disturb fans out to all 24 one cycle after the stages
  chk_dist_fan: assert property (run && s.t == 5'h13 |=> s.dist_stage == 3'h7
    ##1 s.start_dist == 24'hffffff ##1 s.inh_gen == 24'hffffff)
    else $error("disturb fan-out wrong");

  // Unprobed bits never gain a one during a reference
  chk_probe_gate: assert property (run |=>
    ((s.mdr & ~$past(s.mdr)) & ~probe_mask($past(s.probe))) == 24'h000000)
    else $error("unprobed bit captured");

  // Reads probe every group
  chk_read_probe: assert property (!run && start_ref && read_ref |=> ##6 s.probe == 4'hf)
    else $error("read lacks full probes");

  // Each request from idle restarts the chain at zero
  chk_time_restart: assert property (!run && start_ref |=> run && s.t == 5'h00)
    else $error("timing chain did not restart");

  cov_read_ref: cover property (!run && start_ref && read_ref ##25 s.stop_dist[0]);
  cov_part_write: cover property (!run && start_ref && !read_ref && probe_req != 4'h0);
  cov_mixed_inhib: cover property (run && s.t == 5'h0b && s.inh_gen != 24'h000000
    && s.inh_gen != 24'hffffff);

endmodule : core_store_timing

// *** test/core_plane_model.sv ***
// Behavioural model of the core planes, drivers and sense amplifiers.
`timescale 1ns/1ns
module core_plane_model (
  input  wire logic        clk,         // System clock
  input  wire logic        busy,        // Reference in progress
  input  wire logic [4:0]  mem_time,    // Memory time
  input  wire logic        read_cur,    // Read current on
  input  wire logic        write_cur,   // Write current on
  input  wire logic [23:0] inhibit_gen, // Per-plane inhibit on
  output logic      [23:0] sense_in,    // Sense amplifier outputs
  output logic      [23:0] core_word    // Word held in the cores
);
  // ----------------------------------------------------------------
  // Storage and sense behaviour
  // ----------------------------------------------------------------
  logic [23:0] sensed; // Word seen by the read step
  logic [23:0] noise;  // Changes every cycle outside the read window

  initial begin
    core_word = 24'h000000;
    sensed    = 24'h000000;
    noise     = 24'h000000;
  end

  // Cores: read current destroys, write current stores ones where no inhibit
  always @(posedge clk) begin
    noise <= {noise[22:0], ~noise[23]};
    if (!busy) begin
      sensed <= core_word;
    end
    if (read_cur) begin
      core_word <= 24'h000000;
    end else if (write_cur) begin
      core_word <= ~inhibit_gen;
    end
  end

  // Sense valid only up to time 9; junk elsewhere so stray capture shows
  assign sense_in = (busy && mem_time <= 5'h09) ? sensed : noise;
endmodule : core_plane_model

// *** test/test_core_store_timing.sv ***
// Self-checking bench for the core store timing block.
`timescale 1ns/1ns
module test_core_store_timing;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;           // 25 MHz clock
  logic        rst;           // Active high reset
  logic        start_ref;     // Storage request
  logic        read_ref;      // Read when high
  logic [3:0]  probe_req;     // Kept groups on writes
  logic        load_data;     // Data register load
  logic        clear_data;    // Data register clear
  logic [23:0] write_word;    // Word to be written
  logic [23:0] sense_in;      // From the plane model
  logic        busy;          // Reference in progress
  logic [4:0]  mem_time;      // Memory time
  logic        read_cur;      // Read current
  logic        write_cur;     // Write current
  logic        xlate_on;      // Translation live
  logic        stop_xlate;    // Stop translation pulse
  logic [3:0]  read_probe;    // Probe groups
  logic [23:0] start_disturb; // Disturb start
  logic [23:0] stop_inhib;    // Generator stop
  logic [23:0] inhibit_gen;   // Generators
  logic [23:0] data_reg;      // Data register
  logic [23:0] core_word;     // Model's stored word
  logic [23:0] stored;        // Bench's own idea of the stored word
  int          fails;         // Mismatches
  int          n_checks;      // Comparisons

  core_store_timing i_core_store_timing (.clk(clk), .rst(rst), .start_ref(start_ref),
    .read_ref(read_ref), .probe_req(probe_req), .load_data(load_data),
    .clear_data(clear_data), .write_word(write_word), .sense_in(sense_in), .busy(busy),
    .mem_time(mem_time), .read_cur(read_cur), .write_cur(write_cur), .xlate_on(xlate_on),
    .stop_xlate(stop_xlate), .read_probe(read_probe), .start_disturb(start_disturb),
    .stop_inhib(stop_inhib), .inhibit_gen(inhibit_gen), .data_reg(data_reg));
  core_plane_model i_core_plane_model (.clk(clk), .busy(busy), .mem_time(mem_time),
    .read_cur(read_cur), .write_cur(write_cur), .inhibit_gen(inhibit_gen),
    .sense_in(sense_in), .core_word(core_word));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Drive point: a fixed 2 ns after the rising edge
  task automatic step;
    @(posedge clk);
    #2;
  endtask : step

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check_bit

  task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Load a word while idle; clear wins when both are raised
  task automatic load(input logic clr, input logic [23:0] w);
    write_word = w;
    load_data  = 1'b1;
    clear_data = clr;
    step();
    load_data  = 1'b0;
    clear_data = 1'b0;
    check_word(data_reg, clr ? 24'h000000 : w, "load");
  endtask : load

  // One whole reference, checked cycle by cycle against the timing table
  task automatic run_ref(input logic rd, input logic [3:0] keep, input logic [23:0] w);
    logic [3:0] probes;
    probes    = rd ? 4'hf : keep;
    read_ref  = rd;
    probe_req = keep;
    start_ref = 1'b1;
    step();
    for (int m = 0; m < 24; m++) begin
      check_bit(busy, 1'b1, "busy");
      check_word({19'h0, mem_time}, 24'(m), "time");
      check_bit(read_cur, m >= 4 && m <= 9, "read current");
      check_bit(write_cur, m >= 12 && m <= 17, "write current");
      check_bit(xlate_on, m <= 18, "translation");
      check_bit(stop_xlate, m == 19, "stop translation");
      check_word(start_disturb, m == 21 ? 24'hffffff : 24'h000000, "disturb");
      check_word(stop_inhib, 24'h000000, "early stop");
      if (m >= 6)
        check_word({20'h0, read_probe}, {20'h0, probes}, "probes");
      if (m >= 22)
        check_word(inhibit_gen, 24'hffffff, "disturb held");
      else if (m >= 11)
        check_word(inhibit_gen, ~w, "inhibit");
      else
        check_word(inhibit_gen, 24'h000000, "inhibit early");
      // Requests while busy must be ignored
      start_ref  = (m == 5);
      load_data  = (m == 5);
      write_word = ~w;
      step();
    end
    load_data = 1'b0;
    check_bit(busy, 1'b0, "busy end");
    check_word(stop_inhib, 24'hffffff, "stop all");
    check_word(inhibit_gen, 24'h000000, "generators off");
    check_word(data_reg, w, "data register");
    check_word(core_word, w, "cores");
    stored = w;
  endtask : run_ref

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    check_bit(busy, 1'b0, "reset busy");
    check_word(data_reg | inhibit_gen | stop_inhib, 24'h000000, "reset outputs");
  endtask : test_reset

  task automatic test_write_read;
    load(1'b0, 24'h5a3c96);
    run_ref(1'b0, 4'h0, 24'h5a3c96);
    load(1'b1, 24'hffffff);
    run_ref(1'b1, 4'h3, stored);
    load(1'b1, 24'h123456);
    run_ref(1'b1, 4'h0, stored);
  endtask : test_write_read

  // Four partial writes: kept groups come back from the cores
  task automatic test_partial;
    logic [3:0]  modes [4];
    logic [23:0] mask;
    logic [23:0] nw;
    modes = '{4'he, 4'h9, 4'h7, 4'hc};
    for (int i = 0; i < 4; i++) begin
      mask = {{8{modes[i][3]}}, modes[i][2], {7{modes[i][1]}}, {8{modes[i][0]}}};
      nw   = 24'ha5c3e7 ^ {3{8'(i * 8'h35)}};
      load(1'b0, nw & ~mask);
      run_ref(1'b0, modes[i], (stored & mask) | (nw & ~mask));
    end
  endtask : test_partial

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    n_checks = 0;
    stored = 24'h000000;
    {start_ref, read_ref, probe_req, load_data, clear_data, write_word} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    test_reset();
    test_write_read();
    test_partial();
    complete_run();
  end

  // Seven references are run; this is many times that
  initial begin
    #(40 * 3000);
    fails++;
    complete_run();
  end
endmodule : test_core_store_timing
